// file: ttes_edge.sv
`timescale 1ns/1ps
// flags a change of a per-tributary alarm level
module ttes_edge
    import ttes_pkg::*;
#(
    parameter int W = 7
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] level_i,
    output logic [W-1:0] change_o
);
    if (W < 1)
    begin : g_width_check
        $error("ttes_edge: width must be at least one");
    end

    logic [W-1:0] prev_reg;
    logic [W-1:0] prev_next;

    always_comb
    begin
        prev_next = level_i;
        change_o = level_i ^ prev_reg;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            prev_reg <= '0;
        else
            prev_reg <= prev_next;
    end
endmodule : ttes_edge

// file: ttes_pkg.sv
package ttes_pkg;
    localparam int NUM_GRP = 7;
    localparam int WB_AW = 12;
    // register indexes; byte address is four times the index
    localparam logic [WB_AW-1:0] IDX_MM_TU2 = 12'h421;
    localparam logic [WB_AW-1:0] IDX_MM_TU3 = 12'h422;
    localparam logic [WB_AW-1:0] IDX_MM_TU4 = 12'h423;
    localparam logic [WB_AW-1:0] IDX_UN_TU1 = 12'h424;
    localparam logic [WB_AW-1:0] IDX_UN_TU2 = 12'h425;
    localparam logic [WB_AW-1:0] IDX_CTRL = 12'h430;
    localparam logic [WB_AW-1:0] IDX_LAYOUT = 12'h431;
    localparam logic [WB_AW-1:0] IDX_MM_EN = 12'h432;
    localparam logic [WB_AW-1:0] IDX_UN_EN = 12'h433;
    localparam logic [WB_AW-1:0] IDX_MM_STATE = 12'h434;
    localparam logic [WB_AW-1:0] IDX_UN_STATE = 12'h435;
    localparam int CTRL_TU3_BIT = 0;
    localparam logic [13:0] LAYOUT_RESET = 14'h3fff;
    localparam logic [1:0] LAY_TU2 = 2'h0;
    localparam logic [1:0] LAY_VT3 = 2'h1;
    localparam logic [1:0] LAY_TU12 = 2'h2;
    localparam logic [1:0] LAY_TU11 = 2'h3;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } ttes_bus_t;
endpackage : ttes_pkg

// file: ttes_top.sv
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - tu2 mismatch bit x-1 is group x
// - tu3 mismatch bit x-1 is group x
// - tu4 mismatch bit x-1 is group x
// - tu2 unstable bit x-1 is group x
// - tu3 mode: tu1 unstable bit0 is tu3
// - otherwise tu1 unstable bits map groups 1-7
// - tu3 mode zeroes tu2 to tu4 bits
// - tu2 layout zeroes tu2 bits
// - tu2 or vt3 layout zeroes tu3 bit
// - tu2, vt3, tu12 layouts zero tu4 bit
// - bits hold until read; read clears them
// - bits latch regardless of enable
// - mismatch bit sets on every change
// - unstable bit sets on every change
// - two-bit layout selects active tributaries
// - mismatch enable gates interrupt
// - unstable enable gates interrupt
module ttes_top
    import ttes_pkg::*;
#(
    parameter int GROUPS = NUM_GRP
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_AW+1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [6:0] mm_state_tu2_i,
    input wire logic [6:0] mm_state_tu3_i,
    input wire logic [6:0] mm_state_tu4_i,
    input wire logic [6:0] un_state_tu1_i,
    input wire logic [6:0] un_state_tu2_i,
    output logic irq_o
);
    if (GROUPS != NUM_GRP)
    begin : g_groups_check
        $error("ttes_top: only seven groups are supported");
    end

    // mismatch flags [0..2]=tu2..tu4, unstable flags [3..4]=tu1,tu2
    logic [6:0] flag_reg [5];
    logic [6:0] flag_next [5];
    logic [6:0] allow [5];
    logic [6:0] change [5];
    logic [6:0] en_reg [5];
    logic [6:0] en_next [5];
    logic tu3_reg;
    logic tu3_next;
    logic [13:0] layout_reg;
    logic [13:0] layout_next;
    ttes_bus_t bus_reg;
    ttes_bus_t bus_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic irq_reg;
    logic irq_next;
    logic [6:0] mm_en_any;
    logic [6:0] un_en_any;
    logic [34:0] all_level;
    logic [34:0] all_change;

    function automatic logic [1:0] lay_of(input logic [13:0] lay, input int g);
        lay_of = lay[2*g +: 2];
    endfunction : lay_of

    assign all_level = {un_state_tu2_i, un_state_tu1_i, mm_state_tu4_i,
                        mm_state_tu3_i, mm_state_tu2_i};

    ttes_edge #(.W(35)) i_ttes_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .level_i(all_level),
        .change_o(all_change)
    );

    logic req;
    logic [WB_AW-1:0] idx;
    assign req = wb_cyc_i && wb_stb_i && (bus_reg == BUS_IDLE);
    assign idx = wb_adr_i[WB_AW+1:2];

    // which flags exist under the current layout
    always_comb
    begin
        for (int g = 0; g < 7; g++)
        begin
            allow[0][g] = !tu3_reg && lay_of(layout_reg, g) != LAY_TU2;
            allow[1][g] = !tu3_reg && lay_of(layout_reg, g) >= LAY_TU12;
            allow[2][g] = !tu3_reg && lay_of(layout_reg, g) == LAY_TU11;
            allow[3][g] = tu3_reg ? (g == 0) : 1'b1;
            allow[4][g] = allow[0][g];
        end
        for (int r = 0; r < 5; r++)
            change[r] = all_change[7*r +: 7] & allow[r];
    end

    assign mm_en_any = en_reg[0] | en_reg[1] | en_reg[2];
    assign un_en_any = en_reg[3] | en_reg[4];

    always_comb
    begin
        bus_next = BUS_IDLE;
        dat_next = dat_reg;
        tu3_next = tu3_reg;
        layout_next = layout_reg;
        irq_next = 1'b0;
        for (int r = 0; r < 5; r++)
        begin
            // set wins over the read clear; enables never gate latching
            flag_next[r] = (flag_reg[r] | change[r]) & allow[r];
            en_next[r] = en_reg[r];
        end
        if (req)
        begin
            bus_next = BUS_ACK;
            dat_next = '0;
            if (!wb_we_i)
            begin
                case (idx)
                    IDX_MM_TU2: dat_next[6:0] = flag_reg[0] & allow[0];
                    IDX_MM_TU3: dat_next[6:0] = flag_reg[1] & allow[1];
                    IDX_MM_TU4: dat_next[6:0] = flag_reg[2] & allow[2];
                    IDX_UN_TU1: dat_next[6:0] = flag_reg[3] & allow[3];
                    IDX_UN_TU2: dat_next[6:0] = flag_reg[4] & allow[4];
                    IDX_CTRL: dat_next[CTRL_TU3_BIT] = tu3_reg;
                    IDX_LAYOUT: dat_next[13:0] = layout_reg;
                    IDX_MM_EN: dat_next[20:0] = {en_reg[2], en_reg[1], en_reg[0]};
                    IDX_UN_EN: dat_next[13:0] = {en_reg[4], en_reg[3]};
                    IDX_MM_STATE: dat_next[20:0] = all_level[20:0];
                    IDX_UN_STATE: dat_next[13:0] = all_level[34:21];
                    default: dat_next = '0;
                endcase
                for (int r = 0; r < 5; r++)
                    if (idx == IDX_MM_TU2 + WB_AW'(r))
                        flag_next[r] = change[r];
            end
            else
            begin
                case (idx)
                    IDX_CTRL:
                        if (wb_sel_i[0])
                            tu3_next = wb_dat_i[CTRL_TU3_BIT];
                    IDX_LAYOUT:
                    begin
                        if (wb_sel_i[0])
                            layout_next[7:0] = wb_dat_i[7:0];
                        if (wb_sel_i[1])
                            layout_next[13:8] = wb_dat_i[13:8];
                    end
                    IDX_MM_EN:
                    begin
                        if (wb_sel_i[0])
                            en_next[0] = wb_dat_i[6:0];
                        if (wb_sel_i[1])
                            en_next[1] = wb_dat_i[13:7];
                        if (wb_sel_i[2])
                            en_next[2] = wb_dat_i[20:14];
                    end
                    IDX_UN_EN:
                    begin
                        if (wb_sel_i[0])
                            en_next[3] = wb_dat_i[6:0];
                        if (wb_sel_i[1])
                            en_next[4] = wb_dat_i[13:7];
                    end
                    default: dat_next = '0;
                endcase
            end
        end
        for (int r = 0; r < 3; r++)
            irq_next = irq_next | |(flag_next[r] & en_next[r]);
        for (int r = 3; r < 5; r++)
            irq_next = irq_next | |(flag_next[r] & en_next[r]);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bus_reg <= BUS_IDLE;
            dat_reg <= '0;
            tu3_reg <= 1'b0;
            layout_reg <= LAYOUT_RESET;
            irq_reg <= 1'b0;
            for (int r = 0; r < 5; r++)
            begin
                flag_reg[r] <= '0;
                en_reg[r] <= '0;
            end
        end
        else
        begin
            bus_reg <= bus_next;
            dat_reg <= dat_next;
            tu3_reg <= tu3_next;
            layout_reg <= layout_next;
            irq_reg <= irq_next;
            for (int r = 0; r < 5; r++)
            begin
                flag_reg[r] <= flag_next[r];
                en_reg[r] <= en_next[r];
            end
        end
    end

    // one-hot state, so ack leaves its own flip-flop with no decode behind it
    assign wb_ack_o = bus_reg[1];
    assign wb_dat_o = dat_reg;
    assign irq_o = irq_reg;

    property p_mm_set;
        @(posedge clk_i) disable iff (rst_i)
        (change[0][0]) |=> flag_reg[0][0];
    endproperty
    a_mm_set: assert property (p_mm_set) else $error("mismatch change not latched");

    property p_un_set;
        @(posedge clk_i) disable iff (rst_i)
        (change[3][1]) |=> flag_reg[3][1];
    endproperty
    a_un_set: assert property (p_un_set) else $error("unstable change not latched");

    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
        (flag_reg[4][2] && !req && allow[4][2]) |=> flag_reg[4][2];
    endproperty
    a_hold: assert property (p_hold) else $error("flag lost without read");

    property p_tu3_zero;
        @(posedge clk_i) disable iff (rst_i)
        tu3_reg ##1 tu3_reg |-> (flag_reg[0] | flag_reg[1] | flag_reg[2] | flag_reg[4]) == 7'h00;
    endproperty
    a_tu3_zero: assert property (p_tu3_zero) else $error("tu3 mode flag nonzero");

    property p_tu4_zero;
        @(posedge clk_i) disable iff (rst_i)
        (lay_of(layout_reg, 2) != LAY_TU11) [*2] |-> !flag_reg[2][2];
    endproperty
    a_tu4_zero: assert property (p_tu4_zero) else $error("tu4 flag in short layout");

    property p_irq;
        @(posedge clk_i) disable iff (rst_i)
        (|(flag_reg[1] & en_reg[1])) |-> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("enabled flag without irq");

    property p_irq_un;
        @(posedge clk_i) disable iff (rst_i)
        (|(flag_reg[4] & en_reg[4])) |-> irq_o;
    endproperty
    a_irq_un: assert property (p_irq_un) else $error("enabled unstable flag without irq");

    property p_read_clear;
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && idx == IDX_MM_TU2 && change[0] == 7'h00) |=> flag_reg[0] == 7'h00;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read left flags set");

    property p_tu2_zero;
        @(posedge clk_i) disable iff (rst_i)
        (lay_of(layout_reg, 0) == LAY_TU2) [*2] |-> !flag_reg[0][0] && !flag_reg[4][0];
    endproperty
    a_tu2_zero: assert property (p_tu2_zero) else $error("tu2 flag in tu2 layout");

    property p_tu3_lay_zero;
        @(posedge clk_i) disable iff (rst_i)
        (lay_of(layout_reg, 1) <= LAY_VT3) [*2] |-> !flag_reg[1][1];
    endproperty
    a_tu3_lay_zero: assert property (p_tu3_lay_zero) else $error("tu3 flag in short layout");

    property p_tu1_single;
        @(posedge clk_i) disable iff (rst_i)
        tu3_reg ##1 tu3_reg |-> flag_reg[3][6:1] == 6'h00;
    endproperty
    a_tu1_single: assert property (p_tu1_single) else $error("tu1 upper flag in tu3 mode");

    property p_irq_quiet;
        @(posedge clk_i) disable iff (rst_i)
        (un_en_any == 7'h00 && mm_en_any == 7'h00) ##1
        (un_en_any == 7'h00 && mm_en_any == 7'h00) |-> !irq_o;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq with all masked");

    property p_poll;
        @(posedge clk_i) disable iff (rst_i)
        (change[1][4] && !en_reg[1][4]) |=> flag_reg[1][4];
    endproperty
    a_poll: assert property (p_poll) else $error("flag gated by enable");

    property p_ack;
        @(posedge clk_i) disable iff (rst_i)
        req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle");
endmodule : ttes_top

// file: ttes_top_bench.sv
`timescale 1ns/1ps
module ttes_top_bench;
    import ttes_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [WB_AW+1:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic irq_o;
    logic [6:0] mm2 = 7'h00;
    logic [6:0] mm3 = 7'h00;
    logic [6:0] mm4 = 7'h00;
    logic [6:0] un1 = 7'h00;
    logic [6:0] un2 = 7'h00;
    logic [WB_AW-1:0] st_idx [5] = '{IDX_MM_TU2, IDX_MM_TU3, IDX_MM_TU4, IDX_UN_TU1, IDX_UN_TU2};
    logic [31:0] rd_val;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;

    initial
    begin
        forever #2 clk_i = ~clk_i;
    end

    ttes_top i_ttes_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mm_state_tu2_i(mm2), .mm_state_tu3_i(mm3),
        .mm_state_tu4_i(mm4), .un_state_tu1_i(un1), .un_state_tu2_i(un2), .irq_o(irq_o));

    task automatic test_done;
        $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    // a hang anywhere ends up here as a mismatch
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // classic cycle: held until ack is sampled, data taken at that same edge
    task automatic bus(input logic we, input logic [WB_AW-1:0] idx, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
            @(posedge clk_i);
        rd_val = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic rdc(input logic [WB_AW-1:0] idx, input logic [31:0] exp, input string what);
        bus(1'b0, idx, 32'h0);
        chk(what, exp, rd_val);
    endtask : rdc

    task automatic set_lv(input logic [6:0] a, b, c, d, e);
        mm2 <= a;
        mm3 <= b;
        mm4 <= c;
        un1 <= d;
        un2 <= e;
        repeat (4) @(posedge clk_i);
    endtask : set_lv

    // each status register read twice: flags first, then nothing left behind
    task automatic check_all(input logic [34:0] e);
        for (int i = 0; i < 5; i++)
            rdc(st_idx[i], {25'h0, e[7*i +: 7]}, "status");
        for (int i = 0; i < 5; i++)
            rdc(st_idx[i], 32'h0, "status after read");
    endtask : check_all

    task automatic end_test(input string name);
        $display("test %s done, miscompares %0d", name, miscompares);
    endtask : end_test

    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc(IDX_CTRL, 32'h0, "ctrl");
        rdc(IDX_LAYOUT, 32'h3fff, "layout");
        rdc(IDX_MM_EN, 32'h0, "mm enables");
        rdc(IDX_UN_EN, 32'h0, "un enables");
        bus(1'b1, 12'h4ff, 32'hffffffff);
        rdc(12'h4ff, 32'h0, "unmapped");
        bus(1'b1, IDX_MM_TU2, 32'hffffffff);
        check_all(35'h0);
        chk("irq", 32'h0, {31'h0, irq_o});
        end_test("reset");
        // distinct bits per register catch crossed lanes, then every bit rises and falls
        set_lv(7'h01, 7'h02, 7'h40, 7'h08, 7'h10);
        check_all({7'h10, 7'h08, 7'h40, 7'h02, 7'h01});
        set_lv(7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h7f);
        rdc(IDX_MM_STATE, 32'h1fffff, "mm levels");
        rdc(IDX_UN_STATE, 32'h3fff, "un levels");
        check_all({7'h6f, 7'h77, 7'h3f, 7'h7d, 7'h7e});
        set_lv(7'h00, 7'h00, 7'h00, 7'h00, 7'h00);
        check_all({7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h7f});
        chk("irq", 32'h0, {31'h0, irq_o});
        end_test("mapping");
        // group1 tu2, group2 vt3, group3 tu12, the rest tu11
        bus(1'b1, IDX_LAYOUT, 32'h3fe4);
        rdc(IDX_LAYOUT, 32'h3fe4, "layout");
        set_lv(7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h7f);
        check_all({7'h7e, 7'h7f, 7'h78, 7'h7c, 7'h7e});
        set_lv(7'h00, 7'h00, 7'h00, 7'h00, 7'h00);
        check_all({7'h7e, 7'h7f, 7'h78, 7'h7c, 7'h7e});
        bus(1'b1, IDX_LAYOUT, 32'h3fff);
        end_test("layout");
        bus(1'b1, IDX_CTRL, 32'h1);
        rdc(IDX_CTRL, 32'h1, "ctrl");
        set_lv(7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h7f);
        check_all({7'h00, 7'h01, 7'h00, 7'h00, 7'h00});
        set_lv(7'h00, 7'h00, 7'h00, 7'h00, 7'h00);
        check_all({7'h00, 7'h01, 7'h00, 7'h00, 7'h00});
        bus(1'b1, IDX_CTRL, 32'h0);
        end_test("tu3 mode");
        // only tu3 group2 mismatch enabled
        bus(1'b1, IDX_MM_EN, 32'h100);
        rdc(IDX_MM_EN, 32'h100, "mm enables");
        set_lv(7'h00, 7'h00, 7'h00, 7'h01, 7'h00);
        chk("irq", 32'h0, {31'h0, irq_o});
        rdc(IDX_UN_TU1, 32'h1, "polled flag");
        set_lv(7'h00, 7'h02, 7'h00, 7'h01, 7'h00);
        chk("irq", 32'h1, {31'h0, irq_o});
        rdc(IDX_MM_TU3, 32'h2, "mm tu3");
        @(posedge clk_i);
        chk("irq", 32'h0, {31'h0, irq_o});
        bus(1'b1, IDX_UN_EN, 32'h80);
        rdc(IDX_UN_EN, 32'h80, "un enables");
        set_lv(7'h00, 7'h00, 7'h00, 7'h01, 7'h01);
        chk("irq", 32'h1, {31'h0, irq_o});
        rdc(IDX_MM_TU3, 32'h2, "mm tu3 removal");
        @(posedge clk_i);
        chk("irq", 32'h1, {31'h0, irq_o});
        bus(1'b1, IDX_UN_EN, 32'h0);
        @(posedge clk_i);
        chk("irq", 32'h0, {31'h0, irq_o});
        rdc(IDX_UN_TU2, 32'h1, "un tu2");
        end_test("interrupt");
        test_done();
    end
endmodule : ttes_top_bench
